// ===== verilog/pss_sequencer.sv
// slot sequencer with its configuration registers
//
// Overview of operation
// - slot position low nibble is read-only, writes ignored there
// - slot time from 4-bit slot_length code through sixteen-value table
// - slots with no supply wait empty_slot_wait time, same table
// - four LDOs each own a 4-bit switching slot, two per register
// - four bucks each own a 4-bit switching slot, two per register
// - upper nibble selects slot applying pull-down-disable
// - five outputs each have assert slot and separate de-assert slot
// - 32 kHz clock enabled when sequencer reaches clock_enable_slot
// - wait function runs when sequencer reaches wait_slot
// - standby power-down stops at standby_stop_slot, kept 1..system end
// - wait direction bits: never, up, down or both
// - wait-mode 0 waits for general input 3, mode 1 runs timer
`timescale 1ns/1ps
module pss_sequencer
  import pss_pkg::*;
#(
  parameter int unsigned PERIOD_NS     = CLK_PERIOD_NS,
  parameter int unsigned WAIT_BASE_CYC = WAIT_BASE_US * NS_PER_US / PERIOD_NS,
  parameter int unsigned TIMEOUT_CYC   = TIMEOUT_MS * (NS_PER_MS / PERIOD_NS)
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  input  wire logic       power_up_req_in,
  input  wire logic       power_down_req_in,
  input  wire logic       standby_in,
  input  wire logic       general_input_3_in,
  output logic [7:0]      supply_enable_out,
  output logic [4:0]      general_output_out,
  output logic            clk32_enable_out,
  output logic            pulldown_disable_out,
  output logic [3:0]      current_slot_index_out,
  output logic            sequencer_busy_out
);

  // ****************************************
  // register file
  // ****************************************
  logic [7:0] cfg_q [NUM_REGS];
  logic [7:0] cfg_d [NUM_REGS];
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [4:0] idx_w;
  logic [3:0] ptr_q;

  assign idx_w = pss_reg_index(reg_addr_in);

  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = rdata_q;
    if (reg_wr_in && !idx_w[4]) begin
      cfg_d[idx_w[3:0]] = reg_wdata_in;
    end
    if (reg_rd_in) begin
      if (idx_w[4]) begin
        rdata_d = 8'h00;
      end else if (idx_w == IDX_POSITION) begin
        // low nibble always shows the live slot, stored bits unused
        rdata_d = {cfg_q[IDX_POSITION[3:0]][7:4], ptr_q};
      end else begin
        rdata_d = cfg_q[idx_w[3:0]];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        cfg_q[i] <= REG_RESET;
      end
      rdata_q <= REG_RESET;
    end else begin
      cfg_q   <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_out = rdata_q;

  // ****************************************
  // field views
  // ****************************************
  logic [3:0] slot_len_w;
  logic [3:0] empty_wait_w;
  logic [3:0] clk_slot_w;
  logic [3:0] wait_slot_w;
  logic [3:0] pd_slot_w;
  logic [3:0] stop_slot_w;
  logic [3:0] last_slot_w;
  logic [7:0] wctl_w;
  logic [3:0] sup_slot [8];

  assign slot_len_w   = cfg_q[IDX_DURATIONS[3:0]][3:0];
  assign empty_wait_w = cfg_q[IDX_DURATIONS[3:0]][7:4];
  assign clk_slot_w   = cfg_q[IDX_CLK_WAIT[3:0]][7:4];
  assign wait_slot_w  = cfg_q[IDX_CLK_WAIT[3:0]][3:0];
  assign pd_slot_w    = cfg_q[IDX_PULLDOWN[3:0]][7:4];
  assign stop_slot_w  = cfg_q[IDX_STANDBY[3:0]][7:4];
  assign last_slot_w  = cfg_q[IDX_STANDBY[3:0]][3:0];
  assign wctl_w       = cfg_q[IDX_WAIT_CTRL[3:0]];

  // supply order on the enable port: ldo 1..4, then converter 1, 2, 4, 3
  assign sup_slot[0] = cfg_q[IDX_LDO_A[3:0]][3:0];
  assign sup_slot[1] = cfg_q[IDX_LDO_A[3:0]][7:4];
  assign sup_slot[2] = cfg_q[IDX_LDO_B[3:0]][3:0];
  assign sup_slot[3] = cfg_q[IDX_LDO_B[3:0]][7:4];
  assign sup_slot[4] = cfg_q[IDX_BUCK_A[3:0]][3:0];
  assign sup_slot[5] = cfg_q[IDX_BUCK_A[3:0]][7:4];
  assign sup_slot[6] = cfg_q[IDX_BUCK_B[3:0]][7:4];
  assign sup_slot[7] = cfg_q[IDX_BUCK_B[3:0]][3:0];

  // ****************************************
  // input synchroniser
  // ****************************************
  logic gi3_meta_q;
  logic gi3_q;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      gi3_meta_q <= 1'b0;
      gi3_q      <= 1'b0;
    end else begin
      gi3_meta_q <= general_input_3_in;
      gi3_q      <= gi3_meta_q;
    end
  end

  // ****************************************
  // slot matching
  // ****************************************
  pss_state_e st_q;
  pss_state_e st_d;
  logic       up_q;
  logic       start_up_w;
  logic       dir_w;
  logic [3:0] act_w;
  logic [7:0] sup_hit_w;
  logic [4:0] rise_hit_w;
  logic [4:0] fall_hit_w;

  assign start_up_w = power_up_req_in && (ptr_q != last_slot_w);
  assign dir_w      = (st_q == ST_IDLE) ? start_up_w : up_q;
  // going up acts on the slot entered, going down on the slot left
  assign act_w      = dir_w ? ptr_q + 4'h1 : ptr_q;

  for (genvar i = 0; i < 8; i++) begin : g_sup
    assign sup_hit_w[i] = (sup_slot[i] == act_w);
  end

  for (genvar g = 0; g < 5; g++) begin : g_gpo
    assign rise_hit_w[g] =
      (cfg_q[int'(IDX_OUTPUT0) + g][3:0] == act_w);
    assign fall_hit_w[g] =
      (cfg_q[int'(IDX_OUTPUT0) + g][7:4] == act_w);
  end

  // ****************************************
  // sequencer
  // ****************************************
  pss_timer_if tmr ();

  logic [3:0] ptr_d;
  logic       up_d;
  logic [3:0] tgt_q;
  logic [3:0] tgt_d;
  logic [3:0] slot_q;
  logic [3:0] slot_d;
  logic       sby_q;
  logic       sby_d;
  logic       to_q;
  logic       to_d;
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [4:0] gpo_q;
  logic [4:0] gpo_d;
  logic       ck_q;
  logic       ck_d;
  logic       pd_q;
  logic       pd_d;
  logic       step_go;
  logic       fin;
  logic       wait_here;

  assign wait_here = (slot_q == wait_slot_w) &&
    (up_q ? wctl_w[WAIT_DIR_UP] : wctl_w[WAIT_DIR_DN]);

  always_comb begin
    st_d = st_q;
    ptr_d = ptr_q;
    up_d = up_q;
    tgt_d = tgt_q;
    slot_d = slot_q;
    sby_d = sby_q;
    to_d = to_q;
    en_d = en_q;
    gpo_d = gpo_q;
    ck_d = ck_q;
    pd_d = pd_q;
    tmr.load = 1'b0;
    tmr.count = '0;
    step_go = 1'b0;
    fin = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (start_up_w) begin
          up_d = 1'b1;
          tgt_d = last_slot_w;
          step_go = 1'b1;
        end else if (power_down_req_in) begin
          up_d = 1'b0;
          sby_d = standby_in;
          tgt_d = standby_in ? stop_slot_w : SLOT_RESET;
          step_go = (ptr_q > tgt_d);
        end
      end
      ST_SLOT: begin
        if (tmr.done) begin
          if (wait_here && !wctl_w[WAIT_MODE]) begin
            st_d = ST_WAIT_EXT;
            to_d = wctl_w[WAIT_TIMEOUT];
            tmr.load = wctl_w[WAIT_TIMEOUT];
            tmr.count = TMR_W'(TIMEOUT_CYC);
          end else if (wait_here && wctl_w[3:0] != 4'h0) begin
            st_d = ST_WAIT_TMR;
            tmr.load = 1'b1;
            tmr.count = TMR_W'(WAIT_BASE_CYC) << (wctl_w[3:0] - 4'h1);
          end else begin
            fin = 1'b1;
          end
        end
      end
      ST_WAIT_EXT: begin
        fin = gi3_q || (to_q && tmr.done);
      end
      ST_WAIT_TMR: begin
        fin = tmr.done;
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    if (fin) begin
      if (ptr_q != tgt_q) begin
        step_go = 1'b1;
      end else begin
        st_d = ST_IDLE;
      end
    end
    if (step_go) begin
      st_d = ST_SLOT;
      slot_d = act_w;
      ptr_d = dir_w ? ptr_q + 4'h1 : ptr_q - 4'h1;
      tmr.load = 1'b1;
      tmr.count = (|sup_hit_w) ? pss_slot_cycles(slot_len_w, PERIOD_NS) :
        pss_slot_cycles(empty_wait_w, PERIOD_NS);
      for (int i = 0; i < 8; i++) begin
        if (sup_hit_w[i]) begin
          en_d[i] = dir_w;
        end
      end
      for (int g = 0; g < 5; g++) begin
        if (dir_w && rise_hit_w[g]) begin
          gpo_d[g] = 1'b1;
        end
        if (!dir_w && fall_hit_w[g]) begin
          gpo_d[g] = 1'b0;
        end
      end
      if (clk_slot_w == act_w) begin
        ck_d = dir_w;
      end
      if (pd_slot_w == act_w) begin
        pd_d = dir_w;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      st_q   <= ST_IDLE;
      ptr_q  <= SLOT_RESET;
      up_q   <= 1'b0;
      tgt_q  <= SLOT_RESET;
      slot_q <= SLOT_RESET;
      sby_q  <= 1'b0;
      to_q   <= 1'b0;
      en_q   <= 8'h00;
      gpo_q  <= 5'h00;
      ck_q   <= 1'b0;
      pd_q   <= 1'b0;
    end else begin
      st_q   <= st_d;
      ptr_q  <= ptr_d;
      up_q   <= up_d;
      tgt_q  <= tgt_d;
      slot_q <= slot_d;
      sby_q  <= sby_d;
      to_q   <= to_d;
      en_q   <= en_d;
      gpo_q  <= gpo_d;
      ck_q   <= ck_d;
      pd_q   <= pd_d;
    end
  end

  pss_slot_timer u_timer (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .tmr         (tmr.timer)
  );

  assign supply_enable_out      = en_q;
  assign general_output_out     = gpo_q;
  assign clk32_enable_out       = ck_q;
  assign pulldown_disable_out   = pd_q;
  assign current_slot_index_out = ptr_q;
  assign sequencer_busy_out     = (st_q != ST_IDLE);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  ptr_read_only_a: assert property (
    (reg_wr_in && reg_addr_in == ADDR_POSITION && !step_go)
      |=> ptr_q == $past(ptr_q))
    else $error("position write moved slot");
  slot_len_a: assert property (
    (step_go && |sup_hit_w)
      |-> tmr.count == pss_slot_cycles(slot_len_w, PERIOD_NS))
    else $error("slot length wrong");
  empty_len_a: assert property (
    (step_go && !(|sup_hit_w))
      |-> tmr.count == pss_slot_cycles(empty_wait_w, PERIOD_NS))
    else $error("empty slot wait wrong");
  ldo_on_a: assert property (
    (step_go && dir_w && sup_hit_w[0]) |=> supply_enable_out[0])
    else $error("ldo not switched on");
  buck_off_a: assert property (
    (step_go && !dir_w && sup_hit_w[4]) |=> !supply_enable_out[4])
    else $error("converter not switched off");
  pulldown_slot_a: assert property (
    (step_go && pd_slot_w == act_w) |=> pulldown_disable_out == up_q)
    else $error("pull-down disable not applied");
  gpo_rise_a: assert property (
    (step_go && dir_w && rise_hit_w[0]) |=> general_output_out[0])
    else $error("output not asserted");
  clk_enable_a: assert property (
    (step_go && dir_w && clk_slot_w == act_w) |=> clk32_enable_out)
    else $error("clock not enabled");
  wait_enter_a: assert property (
    (st_q == ST_SLOT && tmr.done && !wait_here)
      |=> st_q inside {ST_SLOT, ST_IDLE})
    else $error("wait entered wrongly");
  wait_ext_a: assert property (
    (st_q == ST_WAIT_EXT && !gi3_q && !(to_q && tmr.done))
      |=> st_q == ST_WAIT_EXT)
    else $error("external wait left early");
  standby_stop_a: assert property (
    (st_q != ST_IDLE && st_d == ST_IDLE && !up_q && sby_q)
      |=> ptr_q == stop_slot_w)
    else $error("standby stop slot missed");
  step_up_a: assert property (
    (step_go && dir_w) |=> ptr_q == 4'($past(ptr_q) + 4'h1)
      ##1 (st_q == ST_SLOT) [*1])
    else $error("slot not advanced");
  reserved_kept_a: assert property (
    (reg_wr_in && reg_addr_in == ADDR_PULLDOWN)
      |=> cfg_q[IDX_PULLDOWN[3:0]][3:0] == $past(reg_wdata_in[3:0]))
    else $error("reserved bits lost");
  slot_timed_a: assert property (
    (st_q == ST_SLOT) |-> tmr.busy)
    else $error("slot without running timer");

endmodule

// ===== verilog/pss_pkg.sv
// shared constants and types of the power slot sequencer
package pss_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_POSITION  = 8'h81;
  localparam logic [7:0] ADDR_DURATIONS = 8'h82;
  localparam logic [7:0] ADDR_LDO_A     = 8'h83;
  localparam logic [7:0] ADDR_LDO_B     = 8'h84;
  localparam logic [7:0] ADDR_PULLDOWN  = 8'h88;
  localparam logic [7:0] ADDR_BUCK_A    = 8'h89;
  localparam logic [7:0] ADDR_BUCK_B    = 8'h8a;
  localparam logic [7:0] ADDR_OUTPUT0   = 8'h8d;
  localparam logic [7:0] ADDR_OUTPUT1   = 8'h8e;
  localparam logic [7:0] ADDR_OUTPUT2   = 8'h8f;
  localparam logic [7:0] ADDR_OUTPUT3   = 8'h90;
  localparam logic [7:0] ADDR_OUTPUT4   = 8'h91;
  localparam logic [7:0] ADDR_CLK_WAIT  = 8'h92;
  localparam logic [7:0] ADDR_DOMAIN    = 8'h95;
  localparam logic [7:0] ADDR_STANDBY   = 8'h96;
  localparam logic [7:0] ADDR_WAIT_CTRL = 8'h97;

  // ****************************************
  // storage indexes, bit 4 set means unmapped
  // ****************************************
  localparam int unsigned NUM_REGS = 16;
  localparam logic [4:0] IDX_POSITION  = 5'h00;
  localparam logic [4:0] IDX_DURATIONS = 5'h01;
  localparam logic [4:0] IDX_LDO_A     = 5'h02;
  localparam logic [4:0] IDX_LDO_B     = 5'h03;
  localparam logic [4:0] IDX_PULLDOWN  = 5'h04;
  localparam logic [4:0] IDX_BUCK_A    = 5'h05;
  localparam logic [4:0] IDX_BUCK_B    = 5'h06;
  localparam logic [4:0] IDX_OUTPUT0   = 5'h07;
  localparam logic [4:0] IDX_CLK_WAIT  = 5'h0c;
  localparam logic [4:0] IDX_DOMAIN    = 5'h0d;
  localparam logic [4:0] IDX_STANDBY   = 5'h0e;
  localparam logic [4:0] IDX_WAIT_CTRL = 5'h0f;
  localparam logic [4:0] IDX_NONE      = 5'h10;
  localparam logic [7:0] REG_RESET     = 8'h00;
  localparam logic [3:0] SLOT_RESET    = 4'h0;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned HI_LSB       = 4;
  localparam int unsigned WAIT_DIR_UP  = 6;
  localparam int unsigned WAIT_DIR_DN  = 7;
  localparam int unsigned WAIT_TIMEOUT = 5;
  localparam int unsigned WAIT_MODE    = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NS_PER_US     = 1000;
  localparam int unsigned NS_PER_MS     = 1000000;
  localparam int unsigned SLOT_US [16] = '{32, 64, 96, 128, 160, 192,
    224, 256, 288, 384, 448, 512, 1024, 2048, 4096, 8192};
  localparam int unsigned WAIT_BASE_US = 512;
  localparam int unsigned TIMEOUT_MS   = 500;
  localparam int unsigned TMR_W        = 27;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0001,
    ST_SLOT     = 4'b0010,
    ST_WAIT_EXT = 4'b0100,
    ST_WAIT_TMR = 4'b1000
  } pss_state_e;

  function automatic logic [4:0] pss_reg_index(input logic [7:0] a);
    case (a)
      ADDR_POSITION:  return IDX_POSITION;
      ADDR_DURATIONS: return IDX_DURATIONS;
      ADDR_LDO_A:     return IDX_LDO_A;
      ADDR_LDO_B:     return IDX_LDO_B;
      ADDR_PULLDOWN:  return IDX_PULLDOWN;
      ADDR_BUCK_A:    return IDX_BUCK_A;
      ADDR_BUCK_B:    return IDX_BUCK_B;
      ADDR_OUTPUT0:   return IDX_OUTPUT0;
      ADDR_OUTPUT1:   return 5'h08;
      ADDR_OUTPUT2:   return 5'h09;
      ADDR_OUTPUT3:   return 5'h0a;
      ADDR_OUTPUT4:   return 5'h0b;
      ADDR_CLK_WAIT:  return IDX_CLK_WAIT;
      ADDR_DOMAIN:    return IDX_DOMAIN;
      ADDR_STANDBY:   return IDX_STANDBY;
      ADDR_WAIT_CTRL: return IDX_WAIT_CTRL;
      default:        return IDX_NONE;
    endcase
  endfunction

  // least time, so round up, never below one cycle
  function automatic logic [TMR_W-1:0] pss_slot_cycles(
      input logic [3:0] code, input int unsigned period_ns);
    int unsigned c;
    c = (SLOT_US[code] * NS_PER_US + period_ns - 1) / period_ns;
    if (c == 0) begin
      c = 1;
    end
    return TMR_W'(c);
  endfunction

endpackage

// ===== verilog/pss_timer_if.sv
// load and expiry signals between sequencer and slot timer
`timescale 1ns/1ps
interface pss_timer_if;
  import pss_pkg::*;
  logic             load;
  logic [TMR_W-1:0] count;
  logic             done;
  logic             busy;
  modport ctrl  (output load, output count, input done, input busy);
  modport timer (input load, input count, output done, output busy);
endinterface

// ===== verilog/pss_slot_timer.sv
// down counter that times slots and waits
`timescale 1ns/1ps
module pss_slot_timer
  import pss_pkg::*;
(
  input  wire logic   core_clk_in,
  input  wire logic   rst_in,
  pss_timer_if.timer  tmr
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  // a load of n cycles gives done on the n-th edge after the load
  always_comb begin
    cnt_d = cnt_q;
    if (tmr.load) begin
      cnt_d = tmr.count;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - TMR_W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // not gated by load: the sequencer derives its load from done
  assign tmr.done = (cnt_q == TMR_W'(1));
  assign tmr.busy = (cnt_q != '0);

endmodule

// ===== bench/tb_top.sv
// self-checking bench of the power slot sequencer
`timescale 1ns/1ps
module tb_top;
  import pss_pkg::*;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic       core_clk_in        = 1'b0;
  logic       rst_in             = 1'b1;
  logic [7:0] reg_addr_in        = 8'h00;
  logic [7:0] reg_wdata_in       = 8'h00;
  logic       reg_wr_in          = 1'b0;
  logic       reg_rd_in          = 1'b0;
  logic       power_up_req_in    = 1'b0;
  logic       power_down_req_in  = 1'b0;
  logic       standby_in         = 1'b0;
  logic       general_input_3_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [7:0] supply_enable_out;
  logic [4:0] general_output_out;
  logic       clk32_enable_out;
  logic       pulldown_disable_out;
  logic [3:0] current_slot_index_out;
  logic       sequencer_busy_out;
  int         err_count = 0;
  int         cmp_count = 0;
  logic [7:0] rd_v;

  // mapped offsets and the sequence programmed into them
  localparam logic [7:0] ADDRS [16] = '{ADDR_POSITION, ADDR_DURATIONS,
    ADDR_LDO_A, ADDR_LDO_B, ADDR_PULLDOWN, ADDR_BUCK_A, ADDR_BUCK_B,
    ADDR_OUTPUT0, ADDR_OUTPUT1, ADDR_OUTPUT2, ADDR_OUTPUT3, ADDR_OUTPUT4,
    ADDR_CLK_WAIT, ADDR_DOMAIN, ADDR_STANDBY, ADDR_WAIT_CTRL};
  localparam logic [7:0] CFG [16] = '{8'h00, 8'h01, 8'h21, 8'h00, 8'h30,
    8'h04, 8'h00, 8'h23, 8'h00, 8'h00, 8'h00, 8'h00, 8'h43, 8'h43, 8'h24,
    8'h00};
  // wait control cases: control byte, up and down bounds of slot 3
  localparam logic [7:0] WCTL [5] = '{8'h51, 8'h40, 8'h60, 8'h90, 8'hd1};
  localparam int UPLO [5] = '{36, 100, 52, 32, 36};
  localparam int UPHI [5] = '{38, 106, 56, 32, 38};
  localparam int DNLO [5] = '{32, 32, 32, 32, 36};
  localparam int DNHI [5] = '{32, 32, 32, 32, 38};

  always #50 core_clk_in = ~core_clk_in;

  // period of 1 us per count keeps slots at 32 cycles and up
  pss_sequencer #(
    .PERIOD_NS     (1000),
    .WAIT_BASE_CYC (4),
    .TIMEOUT_CYC   (20)
  ) dut_u (
    .core_clk_in            (core_clk_in),
    .rst_in                 (rst_in),
    .reg_addr_in            (reg_addr_in),
    .reg_wdata_in           (reg_wdata_in),
    .reg_wr_in              (reg_wr_in),
    .reg_rd_in              (reg_rd_in),
    .reg_rdata_out          (reg_rdata_out),
    .power_up_req_in        (power_up_req_in),
    .power_down_req_in      (power_down_req_in),
    .standby_in             (standby_in),
    .general_input_3_in     (general_input_3_in),
    .supply_enable_out      (supply_enable_out),
    .general_output_out     (general_output_out),
    .clk32_enable_out       (clk32_enable_out),
    .pulldown_disable_out   (pulldown_disable_out),
    .current_slot_index_out (current_slot_index_out),
    .sequencer_busy_out     (sequencer_busy_out)
  );

  // ****************************************
  // report and compare
  // ****************************************
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // ****************************************
  // register port, strobes launched at falling edges
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'b1;
    @(negedge core_clk_in);
    reg_wr_in = 1'b0;
    @(negedge core_clk_in);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge core_clk_in);
    reg_rd_in = 1'b0;
    d = reg_rdata_out;
    @(negedge core_clk_in);
  endtask

  // ****************************************
  // sequencer observation
  // ****************************************
  // counts falling edges until the slot index moves; requests last one cycle
  task automatic step(input logic [3:0] idx, input int lo, input int hi);
    int n;
    logic [3:0] prev;
    n = 0;
    prev = current_slot_index_out;
    do begin
      @(negedge core_clk_in);
      power_up_req_in = 1'b0;
      power_down_req_in = 1'b0;
      n++;
    end while (current_slot_index_out === prev && n < 3000);
    if (n >= 3000) begin
      err_count++;
      wrap_up();
    end else begin
      chk({4'h0, current_slot_index_out}, {4'h0, idx});
      chk(8'(n >= lo && n <= hi), 8'h01);
    end
  endtask

  task automatic idle(input int n_exp);
    int n;
    n = 0;
    do begin
      @(negedge core_clk_in);
      n++;
    end while (sequencer_busy_out !== 1'b0 && n < 3000);
    if (n >= 3000) begin
      err_count++;
      wrap_up();
    end else begin
      chk(8'(n), 8'(n_exp));
    end
  endtask

  task automatic outs(input logic [7:0] sup, input logic [4:0] gpo,
                      input logic clk, input logic pd);
    chk(supply_enable_out, sup);
    chk({3'h0, general_output_out}, {3'h0, gpo});
    chk({6'h0, clk32_enable_out, pulldown_disable_out},
        {6'h0, clk, pd});
  endtask

  task automatic run_up(input logic [7:0] wctl, input int lo, input int hi);
    wr(ADDR_WAIT_CTRL, wctl);
    power_up_req_in = 1'b1;
    step(4'h1, 1, 1);
    chk({7'h0, sequencer_busy_out}, 8'h01);
    outs(8'h01, 5'h00, 1'b0, 1'b0);
    // down request while busy must be ignored
    power_down_req_in = 1'b1;
    step(4'h2, 64, 64);
    outs(8'h03, 5'h00, 1'b0, 1'b0);
    step(4'h3, 64, 64);
    outs(8'h03, 5'h01, 1'b0, 1'b1);
    if (wctl[6:4] == 3'b100) begin
      fork
        begin
          repeat (100) @(negedge core_clk_in);
          general_input_3_in = 1'b1;
        end
      join_none
    end
    step(4'h4, lo, hi);
    outs(8'h13, 5'h01, 1'b1, 1'b1);
    idle(64);
    general_input_3_in = 1'b0;
  endtask

  task automatic full_down(input int lo, input int hi);
    power_down_req_in = 1'b1;
    step(4'h3, 1, 1);
    outs(8'h03, 5'h01, 1'b0, 1'b1);
    step(4'h2, 64, 64);
    outs(8'h03, 5'h01, 1'b0, 1'b0);
    step(4'h1, lo, hi);
    outs(8'h01, 5'h00, 1'b0, 1'b0);
    step(4'h0, 64, 64);
    outs(8'h00, 5'h00, 1'b0, 1'b0);
    idle(64);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge core_clk_in);
    rst_in = 1'b0;
    for (int i = 0; i < 16; i++) begin
      rd(ADDRS[i], rd_v);
      chk(rd_v, REG_RESET);
    end
    for (int i = 0; i < 16; i++) begin
      wr(ADDRS[i], 8'ha5 ^ 8'(i));
    end
    for (int i = 0; i < 16; i++) begin
      rd(ADDRS[i], rd_v);
      if (i == 0) begin
        chk(rd_v, 8'ha0);
      end else begin
        chk(rd_v, 8'ha5 ^ 8'(i));
      end
    end
    // unmapped place keeps nothing
    wr(8'h85, 8'hff);
    rd(8'h85, rd_v);
    chk(rd_v, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(ADDRS[i], CFG[i]);
    end
    run_up(8'h00, 32, 32);
    standby_in = 1'b1;
    power_down_req_in = 1'b1;
    step(4'h3, 1, 1);
    step(4'h2, 64, 64);
    idle(32);
    outs(8'h03, 5'h01, 1'b0, 1'b0);
    standby_in = 1'b0;
    wr(ADDR_POSITION, 8'h0f);
    rd(ADDR_POSITION, rd_v);
    chk(rd_v, 8'h02);
    chk({4'h0, current_slot_index_out}, 8'h02);
    power_down_req_in = 1'b1;
    step(4'h1, 1, 1);
    outs(8'h01, 5'h00, 1'b0, 1'b0);
    step(4'h0, 64, 64);
    idle(64);
    outs(8'h00, 5'h00, 1'b0, 1'b0);
    for (int k = 0; k < 5; k++) begin
      run_up(WCTL[k], UPLO[k], UPHI[k]);
      full_down(DNLO[k], DNHI[k]);
    end
    wrap_up();
  end
endmodule
